// [core/ipr_arbiter.sv]
// Priority arbiter: picks the highest-level pending source
`timescale 1ns/100ps
module ipr_arbiter (
	// Requests and their stored levels
	input wire logic [ipr_pkg::IPR_NUM_SRC-1:0] pending,
	input wire logic [ipr_pkg::IPR_NUM_SRC*ipr_pkg::IPR_LVL_W-1:0] levels,
	// Winner
	output logic found,
	output logic [ipr_pkg::IPR_SRC_W-1:0] win_src,
	output logic [ipr_pkg::IPR_LVL_W-1:0] win_lvl
);
	import ipr_pkg::*;

	// Linear scan; strict compare keeps the lowest source index on a tie
	always_comb begin
		found = 1'b0;
		win_src = '0;
		win_lvl = IPR_LVL_LOWEST;
		for (int i = 0; i < IPR_NUM_SRC; i++) begin
			if (pending[i] && (!found || levels[i*IPR_LVL_W +: IPR_LVL_W] > win_lvl)) begin // [R9]
				found = 1'b1;
				win_src = IPR_SRC_W'(i);
				win_lvl = levels[i*IPR_LVL_W +: IPR_LVL_W];
			end
		end
	end

endmodule

// [core/ipr_pkg.sv]
// Shared constants for the interrupt priority register block
package ipr_pkg;

	// Bus and field geometry
	localparam int IPR_ADDR_W = 8;
	localparam int IPR_DATA_W = 32;
	localparam int IPR_REG_W = 16;
	localparam int IPR_LVL_W = 3;
	localparam int IPR_NUM_REGS = 4;
	localparam int IPR_FIELDS_PER_REG = 4;
	localparam int IPR_NUM_SRC = 16;
	localparam int IPR_SRC_W = 4;

	// Register byte offsets
	localparam logic [7:0] IPR_OFF_CN_I2C_NVM = 8'h00;
	localparam logic [7:0] IPR_OFF_CMP3_CAP87_EXT1 = 8'h04;
	localparam logic [7:0] IPR_OFF_EXT2_TMR54_CMP4 = 8'h08;
	localparam logic [7:0] IPR_OFF_CAN1_SPI2_UART2 = 8'h0C;
	localparam logic [7:0] IPR_OFF_ARB_CTRL = 8'h10;
	localparam logic [7:0] IPR_OFF_ARB_STATUS = 8'h14;
	localparam logic [7:0] IPR_OFF_PENDING = 8'h18;

	// Field positions inside each priority register (lsb of each field)
	localparam int IPR_FIELD_LSB_0 = 0;
	localparam int IPR_FIELD_LSB_1 = 4;
	localparam int IPR_FIELD_LSB_2 = 8;
	localparam int IPR_FIELD_LSB_3 = 12;
	localparam int IPR_FIELD_PITCH = 4;

	// Implemented bits: 14-12, 10-8, 6-4, 2-0
	localparam logic [15:0] IPR_IMPL_MASK = 16'h7777;

	// Values after reset
	localparam logic [15:0] IPR_PRIO_RESET = 16'h0000;
	localparam logic IPR_ARB_EN_RESET = 1'b1;

	// Control and status field positions
	localparam int IPR_CTRL_EN_BIT = 0;
	localparam int IPR_STAT_VALID_BIT = 8;
	localparam int IPR_STAT_SRC_LSB = 4;
	localparam int IPR_STAT_LVL_LSB = 0;

	// Level encodings
	localparam logic [2:0] IPR_LVL_LOWEST = 3'h0;
	localparam logic [2:0] IPR_LVL_HIGHEST = 3'h7;

endpackage

// [core/ipr_regs.sv]
// Interrupt priority registers 3 to 6 with APB slave and arbitration
// Behaviour
// [R1] Each field is 3 bits, level 0..7
// [R2] Bits 15, 11, 7, 3 read zero, ignore writes
// [R3] Reset clears every implemented bit
// [R4] First register: change, collision, transfer, write
// [R5] Second register: compare3, capture8, capture7, external1
// [R6] Third register: external2, timer5, timer4, compare4
// [R7] Fourth register: CAN1, SPI2, UART2 transmit, receive
// [R8] Fields read back last written value
// [R9] Higher stored level wins among pending requests
//
// The address map and the APB slave port were decided locally.
`timescale 1ns/100ps
module ipr_regs (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ipr_pkg::IPR_ADDR_W-1:0] paddr,
	input wire logic [ipr_pkg::IPR_DATA_W-1:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [ipr_pkg::IPR_DATA_W-1:0] prdata,
	output logic pready,
	output logic pslverr,
	// Pending and enabled requests, one per source
	input wire logic [ipr_pkg::IPR_NUM_SRC-1:0] src_pending,
	// Stored priorities for the arbitration logic, first register
	output logic [2:0] change_notify_priority,
	output logic [2:0] i2c_collision_priority,
	output logic [2:0] i2c_done_priority,
	output logic [2:0] nonvolatile_write_priority,
	// Second register
	output logic [2:0] compare3_priority,
	output logic [2:0] capture8_priority,
	output logic [2:0] capture7_priority,
	output logic [2:0] external1_priority,
	// Third register
	output logic [2:0] external2_priority,
	output logic [2:0] timer5_priority,
	output logic [2:0] timer4_priority,
	output logic [2:0] compare4_priority,
	// Fourth register
	output logic [2:0] can1_priority,
	output logic [2:0] spi2_priority,
	output logic [2:0] uart2_transmit_priority,
	output logic [2:0] uart2_receive_priority,
	// Arbitration result
	output logic win_valid,
	output logic [ipr_pkg::IPR_SRC_W-1:0] win_source,
	output logic [ipr_pkg::IPR_LVL_W-1:0] win_level
);
	import ipr_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Storage

	logic [IPR_REG_W-1:0] prio_q [IPR_NUM_REGS];
	logic arb_en_q;
	logic arb_en_d;
	logic win_valid_q;
	logic win_valid_d;
	logic [IPR_SRC_W-1:0] win_src_q;
	logic [IPR_SRC_W-1:0] win_src_d;
	logic [IPR_LVL_W-1:0] win_lvl_q;
	logic [IPR_LVL_W-1:0] win_lvl_d;
	logic [IPR_DATA_W-1:0] prdata_q;
	logic [IPR_DATA_W-1:0] prdata_d;
	logic pslverr_q;
	logic pslverr_d;

	////////////////////////////////////////////////////////////////////////
	// APB decode

	// Setup phase captures read data and the error flag; access phase completes in one cycle
	wire setup_phase = psel && !penable;
	wire access_phase = psel && penable;
	wire wr_access = access_phase && pwrite;
	wire rd_setup = setup_phase && !pwrite;
	wire [7:0] addr_word = {paddr[7:2], 2'b00};
	wire addr_aligned = (paddr[1:0] == 2'b00);

	// Register selects
	wire sel_prio0 = addr_aligned && (addr_word == IPR_OFF_CN_I2C_NVM);
	wire sel_prio1 = addr_aligned && (addr_word == IPR_OFF_CMP3_CAP87_EXT1);
	wire sel_prio2 = addr_aligned && (addr_word == IPR_OFF_EXT2_TMR54_CMP4);
	wire sel_prio3 = addr_aligned && (addr_word == IPR_OFF_CAN1_SPI2_UART2);
	wire sel_ctrl = addr_aligned && (addr_word == IPR_OFF_ARB_CTRL);
	wire sel_stat = addr_aligned && (addr_word == IPR_OFF_ARB_STATUS);
	wire sel_pend = addr_aligned && (addr_word == IPR_OFF_PENDING);
	wire [IPR_NUM_REGS-1:0] sel_prio = {sel_prio3, sel_prio2, sel_prio1, sel_prio0};
	wire sel_any = (|sel_prio) || sel_ctrl || sel_stat || sel_pend;

	// Status and pending are read-only; a write to them is an error
	wire ro_hit = sel_stat || sel_pend;
	wire bad_access = !sel_any || (pwrite && ro_hit);

	// Byte lanes 0 and 1 carry the 16-bit registers
	wire [IPR_REG_W-1:0] lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};

	// Zero wait state slave
	assign pready = 1'b1;

	////////////////////////////////////////////////////////////////////////
	// Priority registers

	// One register per loop pass; unimplemented bits are never stored
	for (genvar r = 0; r < IPR_NUM_REGS; r++) begin : g_prio
		logic [IPR_REG_W-1:0] wr_val;
		logic [IPR_REG_W-1:0] prio_d;
		wire do_wr = wr_access && sel_prio[r];

		// Merge by byte lane, then drop bits 15, 11, 7 and 3
		assign wr_val = (pwdata[IPR_REG_W-1:0] & lane_mask) | (prio_q[r] & ~lane_mask);
		assign prio_d = do_wr ? (wr_val & IPR_IMPL_MASK) : prio_q[r]; // [R2] [R8]

		// Power-on clears every field to the lowest level
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				prio_q[r] <= IPR_PRIO_RESET; // [R3]
			end else begin
				prio_q[r] <= prio_d;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Field extraction

	// Source i sits in register i/4, field i%4 counted from bit 0 upward
	logic [IPR_NUM_SRC*IPR_LVL_W-1:0] levels_flat;
	for (genvar s = 0; s < IPR_NUM_SRC; s++) begin : g_field
		localparam int REG = s / IPR_FIELDS_PER_REG;
		localparam int LSB = (s % IPR_FIELDS_PER_REG) * IPR_FIELD_PITCH;
		assign levels_flat[s*IPR_LVL_W +: IPR_LVL_W] = prio_q[REG][LSB +: IPR_LVL_W]; // [R1]
	end

	// First register fields
	assign nonvolatile_write_priority = prio_q[0][IPR_FIELD_LSB_0 +: IPR_LVL_W]; // [R4]
	assign i2c_done_priority = prio_q[0][IPR_FIELD_LSB_1 +: IPR_LVL_W]; // [R4]
	assign i2c_collision_priority = prio_q[0][IPR_FIELD_LSB_2 +: IPR_LVL_W]; // [R4]
	assign change_notify_priority = prio_q[0][IPR_FIELD_LSB_3 +: IPR_LVL_W]; // [R4]

	// Second register fields
	assign external1_priority = prio_q[1][IPR_FIELD_LSB_0 +: IPR_LVL_W]; // [R5]
	assign capture7_priority = prio_q[1][IPR_FIELD_LSB_1 +: IPR_LVL_W]; // [R5]
	assign capture8_priority = prio_q[1][IPR_FIELD_LSB_2 +: IPR_LVL_W]; // [R5]
	assign compare3_priority = prio_q[1][IPR_FIELD_LSB_3 +: IPR_LVL_W]; // [R5]

	// Third register fields
	assign compare4_priority = prio_q[2][IPR_FIELD_LSB_0 +: IPR_LVL_W]; // [R6]
	assign timer4_priority = prio_q[2][IPR_FIELD_LSB_1 +: IPR_LVL_W]; // [R6]
	assign timer5_priority = prio_q[2][IPR_FIELD_LSB_2 +: IPR_LVL_W]; // [R6]
	assign external2_priority = prio_q[2][IPR_FIELD_LSB_3 +: IPR_LVL_W]; // [R6]

	// Fourth register fields
	assign uart2_receive_priority = prio_q[3][IPR_FIELD_LSB_0 +: IPR_LVL_W]; // [R7]
	assign uart2_transmit_priority = prio_q[3][IPR_FIELD_LSB_1 +: IPR_LVL_W]; // [R7]
	assign spi2_priority = prio_q[3][IPR_FIELD_LSB_2 +: IPR_LVL_W]; // [R7]
	assign can1_priority = prio_q[3][IPR_FIELD_LSB_3 +: IPR_LVL_W]; // [R7]

	////////////////////////////////////////////////////////////////////////
	// Arbitration control

	// Enable bit lets software freeze the result while reprogramming
	wire ctrl_wr = wr_access && sel_ctrl && pstrb[0];
	assign arb_en_d = ctrl_wr ? pwdata[IPR_CTRL_EN_BIT] : arb_en_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			arb_en_q <= IPR_ARB_EN_RESET;
		end else begin
			arb_en_q <= arb_en_d;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Arbiter

	logic arb_found;
	logic [IPR_SRC_W-1:0] arb_src;
	logic [IPR_LVL_W-1:0] arb_lvl;

	ipr_arbiter u_arbiter (
		.pending(src_pending),
		.levels(levels_flat),
		.found(arb_found),
		.win_src(arb_src),
		.win_lvl(arb_lvl)
	);

	// Result is registered: one cycle from request, two from a priority write, to output
	assign win_valid_d = arb_en_q ? arb_found : win_valid_q; // [R9]
	assign win_src_d = arb_en_q ? arb_src : win_src_q;
	assign win_lvl_d = arb_en_q ? arb_lvl : win_lvl_q;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			win_valid_q <= 1'b0;
			win_src_q <= '0;
			win_lvl_q <= IPR_LVL_LOWEST;
		end else begin
			win_valid_q <= win_valid_d;
			win_src_q <= win_src_d;
			win_lvl_q <= win_lvl_d;
		end
	end

	assign win_valid = win_valid_q;
	assign win_source = win_src_q;
	assign win_level = win_lvl_q;

	////////////////////////////////////////////////////////////////////////
	// Read path

	// Upper half-word and unused bits always read zero
	wire [IPR_DATA_W-1:0] rd_prio0 = {16'h0000, prio_q[0] & IPR_IMPL_MASK}; // [R2]
	wire [IPR_DATA_W-1:0] rd_prio1 = {16'h0000, prio_q[1] & IPR_IMPL_MASK};
	wire [IPR_DATA_W-1:0] rd_prio2 = {16'h0000, prio_q[2] & IPR_IMPL_MASK};
	wire [IPR_DATA_W-1:0] rd_prio3 = {16'h0000, prio_q[3] & IPR_IMPL_MASK};
	wire [IPR_DATA_W-1:0] rd_ctrl = {31'h00000000, arb_en_q};
	// Valid at bit 8, source at 7:4, bit 3 spare, level at 2:0
	wire [IPR_DATA_W-1:0] rd_stat = {23'h000000, win_valid_q, win_src_q, 1'b0, win_lvl_q};
	wire [IPR_DATA_W-1:0] rd_pend = {16'h0000, src_pending};

	// Read mux; unmapped addresses read zero
	wire [IPR_DATA_W-1:0] rd_mux =
		sel_prio0 ? rd_prio0 :
		sel_prio1 ? rd_prio1 :
		sel_prio2 ? rd_prio2 :
		sel_prio3 ? rd_prio3 :
		sel_ctrl ? rd_ctrl :
		sel_stat ? rd_stat :
		sel_pend ? rd_pend :
		32'h00000000;

	// Read data captured in setup, held through the access phase
	assign prdata_d = rd_setup ? rd_mux : (access_phase ? prdata_q : 32'h00000000); // [R8]

	// Error raised only during the access phase of a bad transfer
	assign pslverr_d = setup_phase && bad_access;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h00000000;
			pslverr_q <= 1'b0;
		end else begin
			prdata_q <= prdata_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign prdata = prdata_q;
	assign pslverr = pslverr_q && access_phase;

endmodule

// [verification/ipr_regs_chk.sv]
// Port checker for the interrupt priority register block
`timescale 1ns/100ps
module ipr_regs_chk (
	// Clock, reset and bus
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	// Requests and fields
	input wire logic [15:0] src_pending,
	input wire logic [2:0] change_notify_priority,
	input wire logic [2:0] nonvolatile_write_priority,
	input wire logic [2:0] compare3_priority,
	input wire logic [2:0] timer4_priority,
	input wire logic [2:0] uart2_receive_priority,
	// Winner
	input wire logic win_valid,
	input wire logic [3:0] win_source,
	input wire logic [2:0] win_level
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire wr = psel && penable && pwrite && pstrb[1:0] == 2'h3;
	wire rd = psel && penable && !pwrite;
	// Any write access, whatever its byte lanes
	wire wr_any = psel && penable && pwrite;
	// Access to one of the four priority registers only
	wire acc_prio = psel && penable && paddr[7:4] == 4'h0 && paddr[1:0] == 2'h0;
	wire rd_prio = acc_prio && !pwrite;
	////////////////////////////////////////////////////////////////
	a_write_first_reg: assert property (wr && paddr == 8'h00 |=>
		change_notify_priority == $past(pwdata[14:12])
		&& nonvolatile_write_priority == $past(pwdata[2:0])) else $error("first reg write lost");
	a_write_fourth_reg: assert property (wr && paddr == 8'h0C |=>
		uart2_receive_priority == $past(pwdata[2:0])) else $error("fourth reg write lost");
	a_read_gaps_zero: assert property (rd_prio |-> prdata[31:15] == 17'h0
		&& !prdata[11] && !prdata[7] && !prdata[3]) else $error("gap bit read nonzero");
	a_read_second_reg: assert property (rd && paddr == 8'h04 |->
		prdata[14:12] == compare3_priority) else $error("second reg read wrong");
	a_read_third_reg: assert property (rd && paddr == 8'h08 |->
		prdata[6:4] == timer4_priority) else $error("third reg read wrong");
	a_field_hold: assert property (!wr_any |=> $stable(change_notify_priority)
		&& $stable(uart2_receive_priority)) else $error("field moved without write");
	a_reset_clear: assert property ($rose(presetn) |->
		compare3_priority == 3'h0 && timer4_priority == 3'h0) else $error("field not cleared");
	a_lone_winner: assert property (src_pending == 16'h0001 |=> win_valid
		&& win_source == 4'h0 && win_level == $past(nonvolatile_write_priority))
		else $error("lone request not chosen");
	a_idle_no_win: assert property (src_pending == 16'h0 |=> !win_valid)
		else $error("winner without request");
	a_prio_no_err: assert property (acc_prio |-> !pslverr)
		else $error("error on priority register access");
endmodule
bind ipr_regs ipr_regs_chk i_ipr_regs_chk (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pstrb, .prdata, .pslverr, .src_pending, .change_notify_priority,
	.nonvolatile_write_priority, .compare3_priority, .timer4_priority,
	.uart2_receive_priority, .win_valid, .win_source, .win_level);

// [verification/ipr_regs_tb.sv]
// Self-checking bench for the interrupt priority register block
`timescale 1ns/100ps
module ipr_regs_tb;
	import ipr_pkg::*;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pslverr, pready;
	logic [7:0] paddr = 8'h00;
	logic [3:0] pstrb = 4'hF;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic [15:0] src_pending = 16'h0;
	logic [2:0] f [16];
	logic win_valid, err;
	logic [3:0] win_source;
	logic [2:0] win_level;
	logic [7:0] offs [4] = '{IPR_OFF_CN_I2C_NVM, IPR_OFF_CMP3_CAP87_EXT1,
		IPR_OFF_EXT2_TMR54_CMP4, IPR_OFF_CAN1_SPI2_UART2};
	int error_cnt = 0, cmp_count = 0, cyc = 0;
	ipr_regs i_ipr_regs (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .src_pending(src_pending),
		.nonvolatile_write_priority(f[0]), .i2c_done_priority(f[1]),
		.i2c_collision_priority(f[2]), .change_notify_priority(f[3]),
		.external1_priority(f[4]), .capture7_priority(f[5]), .capture8_priority(f[6]),
		.compare3_priority(f[7]), .compare4_priority(f[8]), .timer4_priority(f[9]),
		.timer5_priority(f[10]), .external2_priority(f[11]), .uart2_receive_priority(f[12]),
		.uart2_transmit_priority(f[13]), .spi2_priority(f[14]), .can1_priority(f[15]),
		.win_valid(win_valid), .win_source(win_source), .win_level(win_level));
	always #5 pclk = ~pclk;
	// Watchdog at 3000 cycles, well above what the test needs
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			error_cnt++;
			results();
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
			error_cnt++;
		end
	endtask
	// One APB transfer; held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// Register i seen on the field ports, gap bits zero
	function automatic logic [15:0] flds(input int i);
		return {1'b0, f[4*i+3], 1'b0, f[4*i+2], 1'b0, f[4*i+1], 1'b0, f[4*i]};
	endfunction
	////////////////////////////////////////////////////////////////
	task automatic t_reset();
		for (int i = 0; i < 4; i++) begin
			apb(1'b0, offs[i], 32'h0);
			chk("reset read", 32'h0, rd);
			chk("reset fields", 16'h0, flds(i));
		end
	endtask
	// All ones, then a distinct pattern with bit 15 and the upper half-word set
	task automatic t_rw();
		logic [15:0] p;
		for (int i = 0; i < 4; i++) begin
			apb(1'b1, offs[i], 32'hFFFFFFFF);
			apb(1'b0, offs[i], 32'h0);
			chk("ones read", 32'h7777, rd);
			p = 16'hF9AC ^ 16'(i * 16'h1357);
			apb(1'b1, offs[i], {16'hFFFF, p});
			apb(1'b0, offs[i], 32'h0);
			chk("pattern read", {16'h0, p & 16'h7777}, rd);
			chk("field ports", 16'(p & 16'h7777), flds(i));
		end
	endtask
	task automatic t_unmapped();
		apb(1'b0, 8'h40, 32'h0);
		chk("unmapped error", 32'h1, 32'(err));
		chk("unmapped data", 32'h0, rd);
	endtask
	// Pending set by table, winner checked three edges later; exp is valid, level, source
	task automatic t_arb();
		logic [15:0] pend [4] = '{16'hC020, 16'h9000, 16'h0001, 16'h0000};
		logic [7:0] exp [4] = '{8'hD5, 8'hAF, 8'hB0, 8'h00};
		apb(1'b1, offs[0], 32'h0003);
		apb(1'b1, offs[1], 32'h0050);
		apb(1'b1, offs[3], 32'h2500);
		for (int k = 0; k < 4; k++) begin
			@(posedge pclk);
			src_pending <= pend[k];
			repeat (3) @(posedge pclk);
			chk("win valid", 32'(exp[k][7]), 32'(win_valid));
			chk("win level", 32'(exp[k][6:4]), 32'(win_level));
			if (exp[k][7]) chk("win source", 32'(exp[k][3:0]), 32'(win_source));
		end
	endtask
	// Freeze and release arbitration, status, pending and one byte-lane write
	task automatic t_ctrl();
		apb(1'b1, IPR_OFF_ARB_CTRL, 32'h0);
		src_pending <= 16'h0020;
		repeat (3) @(posedge pclk);
		chk("frozen valid", 32'h0, 32'(win_valid));
		apb(1'b0, IPR_OFF_PENDING, 32'h0);
		chk("pending read", 32'h20, rd);
		apb(1'b1, IPR_OFF_ARB_CTRL, 32'h1);
		repeat (3) @(posedge pclk);
		apb(1'b0, IPR_OFF_ARB_STATUS, 32'h0);
		chk("status read", (32'h1 << IPR_STAT_VALID_BIT) | (32'h5 << IPR_STAT_SRC_LSB)
			| (32'h5 << IPR_STAT_LVL_LSB), rd);
		apb(1'b1, IPR_OFF_ARB_STATUS, 32'h0);
		chk("status write error", 32'h1, 32'(err));
		pstrb <= 4'h1;
		apb(1'b1, offs[0], 32'h0000FFFF);
		pstrb <= 4'hF;
		apb(1'b0, offs[0], 32'h0);
		chk("low lane write", 32'h77, rd);
		src_pending <= 16'h0;
	endtask
	task automatic results();
		if (error_cnt == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_rw();
		t_unmapped();
		t_arb();
		t_ctrl();
		results();
	end
endmodule
